//--- hdl/srm_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

`define SRM_ADDR_RESET_CMD 8'h2a
`define SRM_ADDR_IRQ0_MAP_A 8'h2b
`define SRM_RESET_KEY 8'h52
`define SRM_RESET_CMD_RST 8'h00
`define SRM_MAP_A_RST 8'h80
`define SRM_MAP_A_WMASK 8'hef
`define SRM_BIT_FUSE_BUSY 7
`define SRM_BIT_INACT 6
`define SRM_BIT_ACT 5
`define SRM_BIT_RSVD 4
`define SRM_BIT_FIFO_LEVEL 3
`define SRM_BIT_FIFO_OVF 2
`define SRM_BIT_FIFO_FULL 1
`define SRM_BIT_SAMPLE_RDY 0
`define SRM_INIT_TIME_NS 500000
`define SRM_CLK_PERIOD_NS 4
`define SRM_CNT_W 24

`endif

//--- hdl/srm_pkg.sv
// Types shared by the soft reset and pin-0 routing logic.
`include "srm_regs.svh"

package srm_pkg;

  typedef enum logic {
    ST_RUN,
    ST_INIT
  } srm_state_t;

  typedef struct packed {
    srm_state_t state;
    logic [`SRM_CNT_W-1:0] cnt;
    logic [7:0] map;
    logic [7:0] rdData;
    logic standby;
    logic fuseInit;
    logic pinDrive;
    logic irqOut;
  } srm_regs_t;

endpackage

//--- hdl/srm_route_if.sv
// Carrier between the register logic and the pin-0 router.
interface srm_route_if;
  logic [7:0] map;
  logic [7:0] status;
  logic irqLevel;

  modport ctrl (
    output map,
    output status,
    input irqLevel
  );

  modport router (
    input map,
    input status,
    output irqLevel
  );
endinterface

//--- hdl/srm_irq_router.sv
// OR of every pin-0 status condition whose map bit enables it.
`include "srm_regs.svh"

module srm_irq_router #(
  parameter logic FULL_EN_LEVEL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  srm_route_if.router rt
);

  logic [7:0] enabled;
  logic [7:0] hits;

  // ==========================================================
  // Per-bit routing
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      if (i == `SRM_BIT_FIFO_FULL) begin : g_full
        // The filled-FIFO enable uses its own polarity.
        assign enabled[i] = (rt.map[i] == FULL_EN_LEVEL);
      end else if (i == `SRM_BIT_RSVD) begin : g_rsvd
        assign enabled[i] = 1'b0;
      end else begin : g_norm
        assign enabled[i] = rt.map[i];
      end
      assign hits[i] = enabled[i] & rt.status[i];
    end
  endgenerate

  assign rt.irqLevel = |hits;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_ROUTE_ACT: assert property (
    rt.map[`SRM_BIT_ACT] && rt.status[`SRM_BIT_ACT] |-> rt.irqLevel)
    else $error("Enabled activity did not reach pin 0.");
  AST_ROUTE_OFF: assert property (
    (rt.map & `SRM_MAP_A_WMASK) == 8'h02 && !FULL_EN_LEVEL |-> !rt.irqLevel)
    else $error("Pin 0 asserted with every condition disabled.");
endmodule

//--- hdl/srm_reset_map.sv
// Soft reset command and first pin-0 routing register.
`include "srm_regs.svh"

module srm_reset_map #(
  parameter int INIT_CYCLES = `SRM_INIT_TIME_NS / `SRM_CLK_PERIOD_NS,
  parameter logic FULL_EN_LEVEL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic fuseBusyStatus,
  input wire logic inactivityStatus,
  input wire logic activityStatus,
  input wire logic fifoLevelStatus,
  input wire logic fifoOverflowStatus,
  input wire logic fifoFilledStatus,
  input wire logic sampleReadyStatus,
  input wire logic sensorWake,
  output logic softResetActive,
  output logic fuseInitStart,
  output logic sensorStandby,
  output logic firstInterruptPinOut,
  output logic firstInterruptPinOe
);

  localparam logic [`SRM_CNT_W-1:0] INIT_LAST = `SRM_CNT_W'(INIT_CYCLES - 1);

  srm_pkg::srm_regs_t r_reg;
  srm_pkg::srm_regs_t r_next;
  srm_route_if rt ();

  logic keyWrite;
  logic mapWrite;
  logic inInit;

  // ==========================================================
  // Routing of status conditions to pin 0
  // ==========================================================
  assign rt.map = r_reg.map;
  always_comb begin
    rt.status = 8'h00;
    rt.status[`SRM_BIT_FUSE_BUSY] = fuseBusyStatus;
    rt.status[`SRM_BIT_INACT] = inactivityStatus;
    rt.status[`SRM_BIT_ACT] = activityStatus;
    rt.status[`SRM_BIT_FIFO_LEVEL] = fifoLevelStatus;
    rt.status[`SRM_BIT_FIFO_OVF] = fifoOverflowStatus;
    rt.status[`SRM_BIT_FIFO_FULL] = fifoFilledStatus;
    rt.status[`SRM_BIT_SAMPLE_RDY] = sampleReadyStatus;
  end

  srm_irq_router #(
    .FULL_EN_LEVEL(FULL_EN_LEVEL)
  ) u_router (
    .mclk(mclk),
    .rst_n(rst_n),
    .rt(rt)
  );

  // ==========================================================
  // Access decode
  // ==========================================================
  // Address decode shared by the access logic and the checks.
  function automatic logic hitsMap(input logic [7:0] addr);
    return (addr == `SRM_ADDR_IRQ0_MAP_A);
  endfunction

  function automatic logic hitsResetCmd(input logic [7:0] addr);
    return (addr == `SRM_ADDR_RESET_CMD);
  endfunction

  assign inInit = (r_reg.state == srm_pkg::ST_INIT);
  // The key is honoured in any state, so a fresh key restarts the wait.
  assign keyWrite = regWrEn && hitsResetCmd(regAddr)
    && (regWrData == `SRM_RESET_KEY);
  assign mapWrite = regWrEn && !inInit && hitsMap(regAddr);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    r_next = r_reg;
    r_next.fuseInit = 1'b0;
    r_next.rdData = 8'h00;
    if (regRdEn && !inInit) begin
      if (hitsMap(regAddr)) begin
        r_next.rdData = r_reg.map & `SRM_MAP_A_WMASK;
      end else if (hitsResetCmd(regAddr)) begin
        // The trigger is write-only and reserved bits are zero.
        r_next.rdData = `SRM_RESET_CMD_RST;
      end else begin
        r_next.rdData = 8'h00;
      end
    end
    if (sensorWake && !inInit) begin
      r_next.standby = 1'b0;
    end
    if (mapWrite) begin
      r_next.map = regWrData & `SRM_MAP_A_WMASK;
      r_next.pinDrive = 1'b1;
    end
    case (r_reg.state)
      srm_pkg::ST_RUN: begin
        r_next.state = srm_pkg::ST_RUN;
      end
      srm_pkg::ST_INIT: begin
        if (r_reg.cnt == '0) begin
          r_next.state = srm_pkg::ST_RUN;
        end else begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      default: begin
        r_next.state = srm_pkg::ST_RUN;
      end
    endcase
    // Restart: reload the map default, pulse fuse initialisation, put sensors in standby and release pin 0.
    if (keyWrite) begin
      r_next.state = srm_pkg::ST_INIT;
      r_next.cnt = INIT_LAST;
      r_next.map = `SRM_MAP_A_RST;
      r_next.fuseInit = 1'b1;
      r_next.standby = 1'b1;
      r_next.pinDrive = 1'b0;
      r_next.rdData = 8'h00;
    end
    r_next.irqOut = r_next.pinDrive && (r_next.state == srm_pkg::ST_RUN)
      && rt.irqLevel;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg.state <= srm_pkg::ST_RUN;
      r_reg.cnt <= '0;
      r_reg.map <= `SRM_MAP_A_RST;
      r_reg.rdData <= 8'h00;
      r_reg.standby <= 1'b1;
      r_reg.fuseInit <= 1'b0;
      r_reg.pinDrive <= 1'b0;
      r_reg.irqOut <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign regRdData = r_reg.rdData;
  assign softResetActive = inInit;
  assign fuseInitStart = r_reg.fuseInit;
  assign sensorStandby = r_reg.standby;
  assign firstInterruptPinOut = r_reg.irqOut;
  assign firstInterruptPinOe = r_reg.pinDrive && !inInit;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_key;
    regWrEn && regAddr == `SRM_ADDR_RESET_CMD && regWrData == `SRM_RESET_KEY;
  endsequence

  sequence s_bad_key;
    regWrEn && regAddr == `SRM_ADDR_RESET_CMD && regWrData != `SRM_RESET_KEY
      && !inInit;
  endsequence

  AST_KEY_STARTS_INIT: assert property (s_key |=> inInit && r_reg.cnt == INIT_LAST)
    else $error("Key write did not start initialisation.");
  AST_NONKEY_IGNORED: assert property (
    s_bad_key |=> !inInit && r_reg.map == $past(r_reg.map))
    else $error("Non-key write changed state.");
  AST_MAP_DEFAULT: assert property (s_key |=> r_reg.map == `SRM_MAP_A_RST)
    else $error("Map register not restored to default.");
  AST_FUSE_PULSE: assert property (
    s_key ##1 !keyWrite |-> fuseInitStart ##1 !fuseInitStart)
    else $error("Fuse initialisation pulse wrong.");
  AST_STANDBY: assert property (s_key |=> sensorStandby throughout inInit[*2])
    else $error("Sensors left standby during initialisation.");
  AST_PIN_FLOAT: assert property (s_key |=> !firstInterruptPinOe [*2])
    else $error("Pin 0 driven after soft reset.");
  AST_READ_ZERO: assert property (inInit && regRdEn |=> regRdData == 8'h00)
    else $error("Read during initialisation returned data.");
  AST_INIT_COUNT: assert property (
    inInit && r_reg.cnt != '0 && !regWrEn |=> inInit && r_reg.cnt == $past(r_reg.cnt) - 1'b1)
    else $error("Initialisation count did not step.");
  AST_INIT_END: assert property (
    inInit && r_reg.cnt == '0 && !regWrEn |=> !inInit)
    else $error("Initialisation did not end.");
  AST_WRITE_BLOCKED: assert property (
    inInit && regWrEn && regAddr == `SRM_ADDR_IRQ0_MAP_A && !keyWrite
      |=> $stable(r_reg.map))
    else $error("Map written during initialisation.");
  AST_RSVD_ZERO: assert property (r_reg.map[`SRM_BIT_RSVD] == 1'b0)
    else $error("Reserved map bit stored.");
  AST_PIN_FOLLOWS: assert property (
    !inInit && r_reg.pinDrive && !regWrEn |=> firstInterruptPinOut == $past(rt.irqLevel))
    else $error("Pin 0 does not follow routed conditions.");

  // ==========================================================
  // Checks on register access, soft reset state, sensor standby and pin routing
  // ==========================================================
  sequence s_map_write;
    regWrEn && hitsMap(regAddr) && !inInit;
  endsequence

  sequence s_map_read;
    regRdEn && hitsMap(regAddr) && !inInit && !keyWrite;
  endsequence

  // The pin is live and no write can change its gating this cycle.
  sequence s_pin_live;
    !inInit && r_reg.pinDrive && !regWrEn;
  endsequence

  AST_MAP_WRITE: assert property (
    s_map_write |=> r_reg.map == ($past(regWrData) & `SRM_MAP_A_WMASK))
    else $error("Map write did not land.");
  AST_MAP_DRIVES_PIN: assert property (s_map_write |=> firstInterruptPinOe)
    else $error("Pin 0 not driven after a map write.");
  AST_MAP_READ: assert property (
    s_map_read |=> regRdData == ($past(r_reg.map) & `SRM_MAP_A_WMASK))
    else $error("Map read returned wrong data.");
  AST_CMD_READ: assert property (
    regRdEn && hitsResetCmd(regAddr) |=> regRdData == 8'h00)
    else $error("Reset command register read nonzero.");
  AST_READ_STANDS: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("Read data stood past its cycle.");
  AST_RD_KEY: assert property (keyWrite |=> regRdData == 8'h00)
    else $error("Read data nonzero after a key write.");
  AST_MAP_HOLD: assert property (!mapWrite && !keyWrite |=> $stable(r_reg.map))
    else $error("Map changed without an accepted write.");

  AST_STATE_HOLD: assert property (!inInit && !keyWrite |=> !inInit)
    else $error("Initialisation entered without the key.");
  AST_FUSE_KEY_ONLY: assert property (!keyWrite |=> !fuseInitStart)
    else $error("Fuse initialisation started without the key.");
  AST_STANDBY_INIT: assert property (inInit |-> sensorStandby)
    else $error("Sensors awake during initialisation.");
  AST_WAKE: assert property (sensorWake && !inInit && !keyWrite |=> !sensorStandby)
    else $error("Sensors stayed in standby after a wake request.");
  AST_OE_INIT: assert property (inInit |-> !firstInterruptPinOe)
    else $error("Pin 0 driven during initialisation.");
  AST_PIN_QUIET: assert property (!firstInterruptPinOe |-> !firstInterruptPinOut)
    else $error("Pin 0 data high while released.");
  AST_PIN_DROP: assert property (keyWrite |=> !firstInterruptPinOut)
    else $error("Pin 0 data high after a key write.");
  AST_CNT_RANGE: assert property (inInit |-> r_reg.cnt <= INIT_LAST)
    else $error("Initialisation count out of range.");

  AST_PIN_FUSE: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_FUSE_BUSY] && fuseBusyStatus)
      |=> firstInterruptPinOut)
    else $error("Fuse busy did not reach pin 0.");
  AST_PIN_INACT: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_INACT] && inactivityStatus)
      |=> firstInterruptPinOut)
    else $error("Inactivity did not reach pin 0.");
  AST_PIN_ACT: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_ACT] && activityStatus)
      |=> firstInterruptPinOut)
    else $error("Activity did not reach pin 0.");
  AST_PIN_LEVEL: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_FIFO_LEVEL] && fifoLevelStatus)
      |=> firstInterruptPinOut)
    else $error("FIFO watermark did not reach pin 0.");
  AST_PIN_OVF: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_FIFO_OVF] && fifoOverflowStatus)
      |=> firstInterruptPinOut)
    else $error("FIFO overrun did not reach pin 0.");
  AST_PIN_FULL: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_FIFO_FULL] == FULL_EN_LEVEL && fifoFilledStatus)
      |=> firstInterruptPinOut)
    else $error("FIFO full did not reach pin 0.");
  AST_PIN_READY: assert property (
    s_pin_live ##0 (r_reg.map[`SRM_BIT_SAMPLE_RDY] && sampleReadyStatus)
      |=> firstInterruptPinOut)
    else $error("Sample ready did not reach pin 0.");
endmodule

//--- testbench/soft_reset_and_irq0_map_bench.sv
// Self-checking bench for the soft reset command and pin-0 routing register.
`include "srm_regs.svh"

module soft_reset_and_irq0_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int InitCycles = 10;
  logic mclk, rst_n, regWrEn, regRdEn, sensorWake;
  logic [7:0] regAddr, regWrData, regRdData, stat, rdVal;
  logic softResetActive, fuseInitStart, sensorStandby, pinOut, pinOe;
  int n_fail, checks_done, cycles;
  int bitPos[6] = '{7, 6, 5, 3, 2, 0};

  srm_reset_map #(.INIT_CYCLES(InitCycles)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .fuseBusyStatus(stat[7]), .inactivityStatus(stat[6]), .activityStatus(stat[5]),
    .fifoLevelStatus(stat[3]), .fifoOverflowStatus(stat[2]), .fifoFilledStatus(stat[1]),
    .sampleReadyStatus(stat[0]), .sensorWake(sensorWake),
    .softResetActive(softResetActive), .fuseInitStart(fuseInitStart),
    .sensorStandby(sensorStandby), .firstInterruptPinOut(pinOut),
    .firstInterruptPinOe(pinOe)
  );

  // ==========================================================================
  // Clock, timeout and reporting.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // Register port accesses; each ends 1 ns after the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic setStat(input logic [7:0] s);
    @(posedge mclk);
    stat <= s;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    {regWrEn, regRdEn, sensorWake, regAddr, regWrData, stat} = '0;
    rst_n = 1'b0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk({7'h00, pinOe}, 8'h00);
    chk({7'h00, sensorStandby}, 8'h01);
    rd(`SRM_ADDR_IRQ0_MAP_A, rdVal);
    chk(rdVal, `SRM_MAP_A_RST);
    rd(`SRM_ADDR_RESET_CMD, rdVal);
    chk(rdVal, 8'h00);
    rd(8'h2c, rdVal);
    chk(rdVal, 8'h00);
    wr(`SRM_ADDR_IRQ0_MAP_A, 8'hff);
    rd(`SRM_ADDR_IRQ0_MAP_A, rdVal);
    chk(rdVal, 8'hef);
    // Each source other than FIFO full alone must raise the pin; all others must not.
    foreach (bitPos[i]) begin
      wr(`SRM_ADDR_IRQ0_MAP_A, (8'h01 << bitPos[i]) | 8'h02);
      setStat(8'h01 << bitPos[i]);
      chk({7'h00, pinOut}, 8'h01);
      setStat(~(8'h01 << bitPos[i]));
      chk({7'h00, pinOut}, 8'h00);
    end
    wr(`SRM_ADDR_IRQ0_MAP_A, 8'h00);
    setStat(8'h02);
    chk({7'h00, pinOut}, 8'h01);
    chk({7'h00, pinOe}, 8'h01);
    wr(`SRM_ADDR_IRQ0_MAP_A, 8'h02);
    setStat(8'h02);
    chk({7'h00, pinOut}, 8'h00);
    wr(`SRM_ADDR_RESET_CMD, 8'h51);
    chk({7'h00, softResetActive}, 8'h00);
    chk({7'h00, fuseInitStart}, 8'h00);
    rd(`SRM_ADDR_IRQ0_MAP_A, rdVal);
    chk(rdVal, 8'h02);
    setStat(8'hff);
    wr(`SRM_ADDR_RESET_CMD, `SRM_RESET_KEY);
    chk({7'h00, softResetActive}, 8'h01);
    chk({7'h00, fuseInitStart}, 8'h01);
    chk({7'h00, sensorStandby}, 8'h01);
    chk({6'h00, pinOe, pinOut}, 8'h00);
    @(posedge mclk);
    #1;
    chk({7'h00, fuseInitStart}, 8'h00);
    rd(`SRM_ADDR_IRQ0_MAP_A, rdVal);
    chk(rdVal, 8'h00);
    wr(`SRM_ADDR_IRQ0_MAP_A, 8'h01);
    @(posedge mclk);
    sensorWake <= 1'b1;
    @(posedge mclk);
    sensorWake <= 1'b0;
    #1;
    chk({7'h00, sensorStandby}, 8'h01);
    chk({6'h00, pinOe, pinOut}, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h00, softResetActive}, 8'h01);
    @(posedge mclk);
    #1;
    chk({7'h00, softResetActive}, 8'h00);
    rd(`SRM_ADDR_IRQ0_MAP_A, rdVal);
    chk(rdVal, `SRM_MAP_A_RST);
    chk({6'h00, pinOe, pinOut}, 8'h00);
    @(posedge mclk);
    sensorWake <= 1'b1;
    @(posedge mclk);
    sensorWake <= 1'b0;
    @(posedge mclk);
    #1;
    chk({7'h00, sensorStandby}, 8'h00);
    rd(`SRM_ADDR_RESET_CMD, rdVal);
    chk(rdVal, 8'h00);
    stop_test();
  end
endmodule
